// *** scs_consts.svh ***
// Register offsets, field positions and reset values of the serial channel status block.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_OFF_STATUS 8'h00
`define SCS_OFF_STATUS_LO 8'h01
`define SCS_OFF_MASK 8'h02
`define SCS_OFF_VECTOR 8'h03
`define SCS_OFF_EOB 8'h04
`define SCS_BIT_DCD_CHG 15
`define SCS_BIT_CTS_CHG 14
`define SCS_BIT_DCD 13
`define SCS_BIT_CTS 12
`define SCS_BIT_BUSY 11
`define SCS_BIT_BADCFG 10
`define SCS_BIT_RXDATA 9
`define SCS_BIT_TXFREE 8
`define SCS_BIT_BREAK 7
`define SCS_BIT_FRAME 6
`define SCS_BIT_PARITY 5
`define SCS_BIT_OVERRUN 4
`define SCS_BIT_TXEMPTY 3
`define SCS_BIT_TXRDY 2
`define SCS_BIT_FFULL 1
`define SCS_BIT_RECEIVE_CHAR_PRESENT 0
`define SCS_MSK_MODEM 7
`define SCS_MSK_ERROR 6
`define SCS_MSK_BREAK 5
`define SCS_MSK_RXDATA 4
`define SCS_MSK_TXFREE 3
`define SCS_RST_BYTE 8'h00
`define SCS_RST_WORD 16'h0000
`define SCS_LEVEL_OFF 3'h0
`endif

// *** scs_pkg.sv ***
// Types shared by the serial channel status block.
package scs_pkg;
  typedef struct packed {
    logic break_seen;
    logic framing_error;
    logic parity_error;
    logic overrun;
    logic transmitter_empty;
    logic transmitter_ready;
    logic receive_fifo_full;
    logic receive_char_present;
  } scs_rxtx_ev_t;
  typedef struct packed {
    logic modem_change_irq_enable;
    logic error_irq_enable;
    logic line_break_irq_enable;
    logic receive_data_irq_enable;
    logic transmit_space_irq_enable;
    logic [2:0] channel_irq_level;
  } scs_mask_t;
  typedef enum logic [1:0] {
    SCS_IDLE = 2'b00,
    SCS_REQ = 2'b01,
    SCS_ACK = 2'b10
  } scs_irq_state_t;
endpackage

// *** scs_channel_status.sv ***
// Status, interrupt mask, vector and end-of-block logic for one serial channel.
`include "scs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Host alters status only by locked read-modify-write.
// RULE2: Modem line changes set change bits 15, 14.
// RULE3: Bits 13, 12 follow present DCD, CTS levels.
// RULE4: Raising a channel interrupt sets busy bit 11; code sets it only when the request is acknowledged.
// RULE5: Busy anywhere holds interrupts; pending ones are kept.
// RULE6: Illegal field at run start sets bit 10.
// RULE7: End-of-block or timeout sets receive data bit 9.
// RULE8: Host clears receive flag, then kicks receive.
// RULE9: Host clears transmit flag bit 8, then kicks.
// RULE10: Low eight bits sticky; only host clears.
// RULE11: Long space on receive line sets bit 7.
// RULE12: Missing stop bit sets framing bit 6.
// RULE13: Parity error bit 5, never with no parity.
// RULE14: Lost characters set overrun bit 4.
// RULE15: Nothing left to send sets bit 3.
// RULE16: Full receive FIFO sets bit 1.
// RULE17: Character in receive FIFO sets bit 0.
// RULE18: Every enabled event interrupts, even when bit set.
// RULE19: Mask bits 7 to 3 enable event sources.
// RULE20: Level field bits 2-0 picks level; zero disables.
// RULE21: Acknowledge cycle returns the vector register.
// RULE22: Nonzero end-of-block match sets receive flag.
// RULE23: Host leaves control registers alone while running.
module scs_channel_status
  import scs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0] reg_be_i,
  output logic [15:0] reg_rdata_o,
  input wire logic dcd_i,
  input wire logic cts_i,
  input wire scs_rxtx_ev_t rxtx_ev_i,
  input wire logic parity_none_i,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_timeout_i,
  input wire logic tx_space_i,
  input wire logic run_set_i,
  input wire logic config_bad_i,
  input wire logic other_busy_i,
  input wire logic iack_i,
  output logic [2:0] irq_level_o,
  output logic irq_req_o,
  output logic [7:0] irq_vector_o,
  output logic busy_o
);

  logic [15:0] status_q;
  logic [15:0] status_set;
  logic [15:0] status_clr;
  scs_mask_t mask_q;
  logic [7:0] vector_q;
  logic [7:0] eob_q;
  logic dcd_q;
  logic cts_q;
  logic pend_q;
  logic ev_irq;
  logic eob_hit;
  scs_irq_state_t state_q;

  // A received character equal to a nonzero end-of-block code ends the block early.
  assign eob_hit = rx_char_valid_i && (eob_q != `SCS_RST_BYTE) && (rx_char_i == eob_q); // [RULE22]

  always_comb
  begin
    status_set = `SCS_RST_WORD;
    status_set[`SCS_BIT_DCD_CHG] = dcd_i ^ dcd_q; // [RULE2]
    status_set[`SCS_BIT_CTS_CHG] = cts_i ^ cts_q; // [RULE2]
    status_set[`SCS_BIT_BUSY] = (state_q == SCS_REQ) && iack_i; // [RULE4]
    status_set[`SCS_BIT_BADCFG] = run_set_i && config_bad_i; // [RULE6]
    status_set[`SCS_BIT_RXDATA] = eob_hit || rx_timeout_i; // [RULE7]
    status_set[`SCS_BIT_TXFREE] = tx_space_i;
    status_set[`SCS_BIT_BREAK] = rxtx_ev_i.break_seen; // [RULE11]
    status_set[`SCS_BIT_FRAME] = rxtx_ev_i.framing_error; // [RULE12]
    status_set[`SCS_BIT_PARITY] = rxtx_ev_i.parity_error && !parity_none_i; // [RULE13]
    status_set[`SCS_BIT_OVERRUN] = rxtx_ev_i.overrun; // [RULE14]
    // Empty while buffer drained or the host still holds the free flag.
    status_set[`SCS_BIT_TXEMPTY] = rxtx_ev_i.transmitter_empty
      || status_q[`SCS_BIT_TXFREE]; // [RULE15]
    status_set[`SCS_BIT_TXRDY] = rxtx_ev_i.transmitter_ready;
    status_set[`SCS_BIT_FFULL] = rxtx_ev_i.receive_fifo_full; // [RULE16]
    status_set[`SCS_BIT_RECEIVE_CHAR_PRESENT] = rxtx_ev_i.receive_char_present; // [RULE17]
  end

  // The clear mask comes from a status write: a one written clears that bit.
  always_comb
  begin
    status_clr = `SCS_RST_WORD;
    if (reg_wr_i && reg_addr_i == `SCS_OFF_STATUS)
    begin
      status_clr[15:8] = reg_be_i[1] ? reg_wdata_i[15:8] : `SCS_RST_BYTE;
      status_clr[7:0] = reg_be_i[0] ? reg_wdata_i[7:0] : `SCS_RST_BYTE;
    end
  end

  always_comb
  begin
    ev_irq = 1'b0;
    if (mask_q.modem_change_irq_enable)
      ev_irq = ev_irq || status_set[`SCS_BIT_DCD_CHG] || status_set[`SCS_BIT_CTS_CHG];
    if (mask_q.error_irq_enable)
      ev_irq = ev_irq || status_set[`SCS_BIT_FRAME] || status_set[`SCS_BIT_PARITY]
        || status_set[`SCS_BIT_OVERRUN] || status_set[`SCS_BIT_BADCFG];
    if (mask_q.line_break_irq_enable)
      ev_irq = ev_irq || status_set[`SCS_BIT_BREAK];
    if (mask_q.receive_data_irq_enable)
      ev_irq = ev_irq || status_set[`SCS_BIT_RXDATA];
    if (mask_q.transmit_space_irq_enable)
      ev_irq = ev_irq || status_set[`SCS_BIT_TXFREE];
  end // [RULE19]

  // Change bits, busy and host flags are sticky; the low byte never clears itself.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= `SCS_RST_WORD;
    else
    begin
      status_q <= status_set | (status_q & ~status_clr); // [RULE10] [RULE1] [RULE8] [RULE9]
      status_q[`SCS_BIT_DCD] <= dcd_i; // [RULE3]
      status_q[`SCS_BIT_CTS] <= cts_i; // [RULE3]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dcd_q <= 1'b0;
      cts_q <= 1'b0;
    end
    else
    begin
      dcd_q <= dcd_i;
      cts_q <= cts_i;
    end
  end

  // Control registers take writes at any time; the host keeps them still while running.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= `SCS_RST_BYTE;
      vector_q <= `SCS_RST_BYTE;
      eob_q <= `SCS_RST_BYTE;
    end
    else if (reg_wr_i && reg_be_i[0])
    begin
      if (reg_addr_i == `SCS_OFF_MASK)
        mask_q <= reg_wdata_i[7:0];
      else if (reg_addr_i == `SCS_OFF_VECTOR)
        vector_q <= reg_wdata_i[7:0];
      else if (reg_addr_i == `SCS_OFF_EOB)
        eob_q <= reg_wdata_i[7:0];
    end
  end

  // Pending survives a busy hold, so no enabled event is forgotten.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (ev_irq)
      pend_q <= 1'b1; // [RULE18]
    else if (state_q == SCS_REQ && iack_i)
      pend_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= SCS_IDLE;
    else
    begin
      case (state_q)
        SCS_IDLE:
          if (pend_q && !status_q[`SCS_BIT_BUSY] && !other_busy_i
              && mask_q.channel_irq_level != `SCS_LEVEL_OFF) // [RULE5] [RULE20]
            state_q <= SCS_REQ;
        SCS_REQ:
          if (iack_i)
            state_q <= SCS_ACK;
          else if (mask_q.channel_irq_level == `SCS_LEVEL_OFF)
            state_q <= SCS_IDLE; // [RULE20]
        SCS_ACK:
          state_q <= SCS_IDLE;
        default:
          state_q <= SCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_req_o <= 1'b0;
      irq_level_o <= `SCS_LEVEL_OFF;
      irq_vector_o <= `SCS_RST_BYTE;
      busy_o <= 1'b0;
    end
    else
    begin
      irq_req_o <= (state_q == SCS_IDLE && pend_q && !status_q[`SCS_BIT_BUSY]
        && !other_busy_i && mask_q.channel_irq_level != `SCS_LEVEL_OFF)
        || (state_q == SCS_REQ && !iack_i
        && mask_q.channel_irq_level != `SCS_LEVEL_OFF);
      irq_level_o <= mask_q.channel_irq_level; // [RULE20]
      irq_vector_o <= vector_q; // [RULE21]
      busy_o <= status_set[`SCS_BIT_BUSY] || (status_q[`SCS_BIT_BUSY]
        && !status_clr[`SCS_BIT_BUSY]); // [RULE5]
    end
  end

  // Read data is registered, one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= `SCS_RST_WORD;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `SCS_OFF_STATUS)
        reg_rdata_o <= status_q;
      else if (reg_addr_i == `SCS_OFF_MASK)
        reg_rdata_o <= {`SCS_RST_BYTE, mask_q};
      else if (reg_addr_i == `SCS_OFF_VECTOR)
        reg_rdata_o <= {`SCS_RST_BYTE, vector_q};
      else if (reg_addr_i == `SCS_OFF_EOB)
        reg_rdata_o <= {`SCS_RST_BYTE, eob_q};
      else
        reg_rdata_o <= `SCS_RST_WORD;
    end
  end

endmodule
`default_nettype wire

// *** scs_sva.sv ***
// Port-level assertions for the serial channel status block.
`timescale 1ns/1ps
`default_nettype none
module scs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0] reg_be_i,
  input wire logic iack_i,
  input wire logic [2:0] irq_level_o,
  input wire logic irq_req_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic clr = reg_wr_i && reg_addr_i == 8'h00 && reg_be_i[1] && reg_wdata_i[11];
  wire logic mwr = reg_wr_i && reg_be_i[0];
  property p_ack; iack_i && irq_req_o |=> busy_o && !irq_req_o; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not taken");
  property p_rise; $rose(busy_o) |-> $past(iack_i); endproperty
  a_rise: assert property (p_rise) else $error("busy without acknowledge");
  property p_hold; busy_o |-> !irq_req_o; endproperty
  a_hold: assert property (p_hold) else $error("request while busy");
  property p_keep; busy_o && !clr |=> busy_o; endproperty
  a_keep: assert property (p_keep) else $error("busy lost");
  property p_clr; clr && !iack_i |=> !busy_o; endproperty
  a_clr: assert property (p_clr) else $error("busy not cleared");
  property p_lvl0; irq_level_o == 3'h0 [*2] |-> !irq_req_o; endproperty
  a_lvl0: assert property (p_lvl0) else $error("request at level zero");
  property p_lvl; mwr && reg_addr_i == 8'h02 |=> ##1 irq_level_o == $past(reg_wdata_i[2:0], 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level mismatch");
  property p_vec; mwr && reg_addr_i == 8'h03 |=> ##1 irq_vector_o == $past(reg_wdata_i[7:0], 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector mismatch");
  cover property (iack_i && irq_req_o);
  cover property (clr && busy_o);
  cover property ($rose(irq_req_o) && irq_level_o != 3'h0);
endmodule
`default_nettype wire

// *** scs_host_model.sv ***
// Host that acknowledges channel interrupt requests after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic [3:0] dly_i,
  output logic iack_o
);
  int n;
  // A slow host lets the request stand for a while before it acknowledges.
  always_ff @(posedge clk_i)
  begin
    n <= (rst_i || !irq_req_i || iack_o) ? 0 : n + 1;
    iack_o <= !rst_i && irq_req_i && !iack_o && n >= int'(dly_i);
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the serial channel status block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scs_pkg::*;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, rd_d = 0, dcd = 0, cts = 0, pn = 0, bad = 0, ob = 0;
  logic [7:0] a = 0, rc = 0, v, vec;
  logic [15:0] wd = 0, rdat, q[$];
  logic [1:0] be = 0;
  logic [11:0] pv = 0;
  logic [3:0] dly;
  logic [2:0] lvl;
  logic req, iack, busy;
  int err_total = 0, total_checks = 0;
  scs_channel_status uut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(a), .reg_wdata_i(wd), .reg_be_i(be), .reg_rdata_o(rdat), .dcd_i(dcd),
    .cts_i(cts), .rxtx_ev_i(pv[7:0]), .parity_none_i(pn), .rx_char_valid_i(pv[10]),
    .rx_char_i(rc), .rx_timeout_i(pv[8]), .tx_space_i(pv[9]), .run_set_i(pv[11]),
    .config_bad_i(bad), .other_busy_i(ob), .iack_i(iack), .irq_level_o(lvl),
    .irq_req_o(req), .irq_vector_o(vec), .busy_o(busy));
  scs_host_model hm (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(req), .dly_i(dly), .iack_o(iack));
  initial forever #5 clk_i = ~clk_i;
  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge clk_i) rd_d <= rd;
  always @(negedge clk_i) if (rd_d) chk("rdata", q.pop_front(), rdat);
  task automatic wr16(logic [7:0] ad, logic [15:0] d, logic [1:0] b);
    @(negedge clk_i);
    {wr, a, wd, be} = {1'b1, ad, d, b};
    @(negedge clk_i);
    wr = 0;
  endtask
  task automatic rd16(logic [7:0] ad, logic [15:0] e);
    @(negedge clk_i);
    {rd, a} = {1'b1, ad};
    q.push_back(e);
    @(negedge clk_i);
    rd = 0;
  endtask
  task automatic go(logic [11:0] p);
    @(negedge clk_i);
    pv = p;
    @(negedge clk_i);
    pv = 0;
  endtask
  task automatic wait_req(logic w);
    for (int i = 0; i < 50 && req !== w; i++) @(negedge clk_i);
    if (req !== w)
    begin
      chk("irq_req", 16'(w), 16'(req));
      final_report();
    end
  endtask
  task automatic idle_chk();
    repeat (6) @(negedge clk_i);
    chk("irq_req", 16'h0000, 16'(req));
  endtask
  initial
  begin
    void'($urandom(62137));
    dly = 4'($urandom_range(0, 5));
    v = 8'($urandom);
    repeat (6) @(negedge clk_i);
    rst_i = 0;
    for (int i = 0; i < 6; i++) rd16(8'(i), 16'h0000);
    wr16(8'h03, {8'h00, v}, 2'b01);
    rd16(8'h03, {8'h00, v});
    wr16(8'h02, 16'h0081, 2'b01);
    rd16(8'h02, 16'h0081);
    chk("vector", {8'h00, v}, {8'h00, vec});
    dcd = 1;
    wait_req(1);
    wait_req(0);
    chk("busy", 16'h0001, 16'(busy));
    rd16(8'h00, 16'hA800);
    cts = 1;
    idle_chk();
    rd16(8'h00, 16'hF800);
    wr16(8'h00, 16'hC800, 2'b10);
    wait_req(1);
    wait_req(0);
    wr16(8'h00, 16'h0800, 2'b10);
    rd16(8'h00, 16'h3000);
    wr16(8'h02, 16'h0080, 2'b01);
    cts = 0;
    idle_chk();
    ob = 1;
    wr16(8'h02, 16'h0081, 2'b01);
    idle_chk();
    ob = 0;
    wait_req(1);
    wait_req(0);
    wr16(8'h00, 16'h4800, 2'b10);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 2; j++)
      begin
        wr16(8'h02, 16'(8'h40 >> k) | 16'h0001, 2'b01);
        go(12'h040 << k);
        wait_req(1);
        wait_req(0);
        wr16(8'h00, 16'h0800, 2'b10);
      end
    rd16(8'h00, 16'h23C8);
    wr16(8'h00, 16'h0100, 2'b10);
    rd16(8'h00, 16'h22C8);
    wr16(8'h00, 16'hFFFF, 2'b11);
    go(12'h03F);
    rd16(8'h00, 16'h203F);
    wr16(8'h00, 16'h00FF, 2'b01);
    pn = 1;
    go(12'h020);
    wr16(8'h04, 16'h000D, 2'b01);
    rc = 8'h0D ^ 8'($urandom_range(1, 255));
    go(12'h400);
    rd16(8'h00, 16'h2000);
    rc = 8'h0D;
    go(12'h400);
    go(12'h800);
    rd16(8'h00, 16'h2200);
    bad = 1;
    go(12'h800);
    rd16(8'h00, 16'h2600);
    final_report();
  end
endmodule
bind scs_channel_status scs_sva u_sva (.clk_i, .rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
  .reg_be_i, .iack_i, .irq_level_o, .irq_req_o, .irq_vector_o, .busy_o);
`default_nettype wire
